// ---- rtl/tsec_regs.vh ----
// Purpose: Constants for the two-stage event controller
// Assumes: Register index on mmr_idx, one 32-bit word each
// Notes:   Included by every design file of the block
`ifndef TSEC_REGS_VH
`define TSEC_REGS_VH

// ****************************************************************
// Register indices
// ****************************************************************
`define TSEC_IDX_LATCH      4'h0
`define TSEC_IDX_MASK       4'h1
`define TSEC_IDX_PENDING    4'h2
`define TSEC_IDX_PMASK_LO   4'h3
`define TSEC_IDX_PMASK_HI   4'h4
`define TSEC_IDX_PSTAT_LO   4'h5
`define TSEC_IDX_PSTAT_HI   4'h6
`define TSEC_IDX_PWAKE_LO   4'h7
`define TSEC_IDX_PWAKE_HI   4'h8
`define TSEC_IDX_ASSIGN0    4'h9

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define TSEC_GP_FIRST       4
`define TSEC_GP_BASE        7
`define TSEC_SW_LO          14
`define TSEC_RSVD_CLASS     4
`define TSEC_ASSIGN_W       4
`define TSEC_ASSIGN_KEEP    32'h77777777
`define TSEC_MASK_FIXED     16'h001F
`define TSEC_MASK_RESET     16'h001F
`define TSEC_GLOBAL_RESET   1'b1
`define TSEC_ASSIGN_RESET   {32'h33333000, 32'h06666655, 32'h55555555, 32'h44444433, 32'h33332222, 32'h11000000, 32'h00000000}

`endif

// ---- rtl/tsec_level_map.v ----
// Purpose: Level assignment store and per-level request routing
// Assumes: Peripheral requests are levels on the core clock
// Notes:   Read data is registered, valid the cycle after rd_en
`timescale 1ns/1ps
`include "tsec_regs.vh"

module tsec_level_map #(
  parameter NSRC = 56,
  parameter NREG = 7
) (
  input  wire                clk,
  input  wire                resetn,
  input  wire                wr_en,
  input  wire                rd_en,
  input  wire [2:0]          idx,
  input  wire [31:0]         wdata,
  input  wire [NSRC-1:0]     periph_req,
  input  wire [NSRC-1:0]     periph_mask,
  input  wire [15:0]         pending,
  output reg  [31:0]         rd_data_q,
  output reg  [6:0]          gp_line,
  output wire [NSRC-1:0]     periph_ack
);

  reg  [NREG*32-1:0] asg_q;
  wire [NSRC*7-1:0]  onehot;
  integer            s;
  integer            l;

  // ****************************************************************
  // Assignment registers
  // ****************************************************************
  always @(posedge clk) begin
    if (!resetn) begin
      asg_q     <= `TSEC_ASSIGN_RESET;
      rd_data_q <= 32'h00000000;
    end else begin
      if (wr_en && idx < NREG)
        asg_q[idx*32 +: 32] <= wdata & `TSEC_ASSIGN_KEEP; // R3
      if (rd_en)
        rd_data_q <= (idx < NREG) ? asg_q[idx*32 +: 32] : 32'h00000000;
    end
  end

  // ****************************************************************
  // Per-source routing
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < NSRC; i = i + 1) begin : g_src
      wire [2:0] code = asg_q[i*`TSEC_ASSIGN_W +: 3]; // R5
      wire       live = periph_req[i] & periph_mask[i]; // R13
      assign onehot[i*7 +: 7] = (code == 3'h7) ? 7'h00 : ({6'h00, live} << code); // R4
      assign periph_ack[i]    = live & (code != 3'h7) & pending[{1'b0, code} + 4'h7]; // R17
    end
  endgenerate

  always @* begin
    gp_line = 7'h00;
    for (s = 0; s < NSRC; s = s + 1)
      for (l = 0; l < 7; l = l + 1)
        gp_line[l] = gp_line[l] | onehot[s*7+l]; // R21 R16
  end

endmodule // tsec_level_map

// ---- rtl/tsec_event_ctrl.v ----
// Purpose: Two-stage event controller, system and core stages
// Assumes: One core clock; requests and core strobes on that clock
// Notes:   Registers reached over the supervisor register port
//
// What this block does
// [R1] Sixteen event classes ranked by number, zero most urgent.
// [R2] Nine general levels; the two least urgent kept for software.
// [R3] Assignment registers let software remap each source's level.
// [R4] Sources 0 to 55 accepted; reset map drives levels 7 to 13.
// [R5] Assignment code 0 to 6 selects level code plus seven, eight per register.
// [R6] Mask, status, wakeup registers in low and high 32-bit pairs.
// [R7] Core latch, mask, pending registers, 16 bits, one per class.
// [R8] Latch bit set on capture, cleared on acceptance, by hardware.
// [R9] Latch bit writable only while its core mask bit is clear.
// [R10] Set core mask bit allows service; clear blocks but still latches.
// [R11] Core mask read/write in supervisor; global on and off for levels.
// [R12] Pending bit holds while event active or nested; supervisor readable.
// [R13] Set peripheral mask bit passes request; clear blocks it.
// [R14] Peripheral status bit reads one while source requests.
// [R15] Wake-enabled source requesting while core idle wakes the core.
// [R16] Shared level inputs tolerate simultaneous and overlapping pulses.
// [R17] System stage takes core pending bits as acknowledgement.
// [R18] Rising edge on a level sets its latch; detection takes two cycles.
// [R19] Latch clears as pending sets; next rising edge is then captured.
// [R20] Edge to pending bit takes at least three core cycles.
// [R21] Each level input is OR of unmasked requests assigned to it.
// [R22] Most urgent latched unmasked class served, nesting over less urgent.
`timescale 1ns/1ps
`include "tsec_regs.vh"

module tsec_event_ctrl #(
  parameter NSRC = 56
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [NSRC-1:0]  periph_req,
  input  wire [6:0]       core_evt,
  input  wire             core_idle,
  input  wire             global_irq_on,
  input  wire             global_irq_off,
  input  wire             svc_take,
  input  wire             svc_ret,
  input  wire             mmr_sup,
  input  wire             mmr_wr,
  input  wire             mmr_rd,
  input  wire [3:0]       mmr_idx,
  input  wire [31:0]      mmr_wdata,
  output wire [31:0]      mmr_rdata,
  output reg              mmr_rvalid,
  output reg              mmr_err,
  output wire             svc_req,
  output reg  [3:0]       svc_class,
  output reg              wake_core,
  output wire [NSRC-1:0]  periph_ack
);

  reg  [15:0]       latch_q;
  reg  [15:0]       latch_d;
  reg  [15:0]       mask_q;
  reg  [15:0]       pend_q;
  reg  [15:0]       pend_d;
  reg               glob_en_q;
  reg  [15:0]       line_q;
  reg  [15:0]       prev_q;
  reg  [NSRC-1:0]   pmask_q;
  reg  [NSRC-1:0]   pwake_q;
  reg               sel_valid_q;
  reg  [31:0]       rdata_q;
  reg               map_sel_q;
  wire [31:0]       map_rdata;
  wire [6:0]        gp_line;
  wire [15:0]       ev_line;
  wire [15:0]       edge_det;
  wire [15:0]       mask_eff;
  wire [15:0]       cand;
  wire [15:0]       pend_low;
  wire [4:0]        best;
  wire [4:0]        top;
  wire              acc_ok;
  wire              wr_ok;
  wire              rd_ok;
  wire              is_map;
  wire              take;
  wire [63:0]       pmask_w;
  wire [63:0]       pstat_w;
  wire [63:0]       pwake_w;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [4:0] first_set;
    input [15:0] v;
    integer k;
    begin
      first_set = 5'h10;
      for (k = 15; k >= 0; k = k - 1)
        if (v[k])
          first_set = k[4:0];
    end
  endfunction

  assign acc_ok = mmr_sup;
  assign wr_ok  = mmr_wr & acc_ok;
  assign rd_ok  = mmr_rd & acc_ok;
  assign is_map = (mmr_idx >= `TSEC_IDX_ASSIGN0);

  assign pmask_w = {{(64-NSRC){1'b0}}, pmask_q};
  assign pstat_w = {{(64-NSRC){1'b0}}, periph_req}; // R14
  assign pwake_w = {{(64-NSRC){1'b0}}, pwake_q};

  // ****************************************************************
  // System stage routing
  // ****************************************************************
  tsec_level_map #(
    .NSRC (NSRC),
    .NREG (7)
  ) u_map (
    .clk         (clk),
    .resetn      (resetn),
    .wr_en       (wr_ok & is_map),
    .rd_en       (rd_ok & is_map),
    .idx         (mmr_idx[2:0] - 3'h1),
    .wdata       (mmr_wdata),
    .periph_req  (periph_req),
    .periph_mask (pmask_q),
    .pending     (pend_q),
    .rd_data_q   (map_rdata),
    .gp_line     (gp_line),
    .periph_ack  (periph_ack)
  );

  // Levels 14 and 15 have no peripheral line
  assign ev_line = {2'b00, gp_line, core_evt[6:5], 1'b0, core_evt[3:0]}; // R2 R1

  // ****************************************************************
  // Core stage edge detection
  // ****************************************************************
  always @(posedge clk) begin
    if (!resetn) begin
      line_q <= 16'h0000;
      prev_q <= 16'h0000;
    end else begin
      line_q <= ev_line;
      prev_q <= line_q;
    end
  end

  assign edge_det = line_q & ~prev_q; // R18

  // ****************************************************************
  // Selection
  // ****************************************************************
  assign mask_eff = {mask_q[15:7] & {9{glob_en_q}}, mask_q[6:0]}; // R11
  assign cand     = latch_q & mask_eff; // R10
  assign best     = first_set(cand);
  assign top      = first_set(pend_q);
  assign pend_low = pend_q & (~pend_q + 16'h0001);

  always @(posedge clk) begin
    if (!resetn) begin
      sel_valid_q <= 1'b0;
      svc_class   <= 4'h0;
    end else begin
      sel_valid_q <= (best < top); // R22 R1
      svc_class   <= best[3:0];
    end
  end

  assign svc_req = sel_valid_q & latch_q[svc_class] & mask_eff[svc_class] & ~pend_q[svc_class];
  assign take    = svc_req & svc_take;

  // ****************************************************************
  // Latch and pending
  // ****************************************************************
  always @* begin
    latch_d = latch_q;
    if (wr_ok && mmr_idx == `TSEC_IDX_LATCH)
      latch_d = (latch_q & mask_q) | (mmr_wdata[15:0] & ~mask_q); // R9
    if (take)
      latch_d[svc_class] = 1'b0; // R19 R8
    latch_d = latch_d | edge_det; // R8 R16
    latch_d[`TSEC_RSVD_CLASS] = 1'b0;
  end

  always @* begin
    pend_d = pend_q;
    if (svc_ret)
      pend_d = pend_d & ~pend_low; // R12
    if (take)
      pend_d[svc_class] = 1'b1; // R12 R20
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  always @(posedge clk) begin
    if (!resetn) begin
      latch_q   <= 16'h0000;
      pend_q    <= 16'h0000;
      mask_q    <= `TSEC_MASK_RESET;
      glob_en_q <= `TSEC_GLOBAL_RESET;
      pmask_q   <= {NSRC{1'b0}};
      pwake_q   <= {NSRC{1'b0}};
    end else begin
      latch_q <= latch_d; // R7
      pend_q  <= pend_d;
      if (global_irq_on)
        glob_en_q <= 1'b1; // R11
      else if (global_irq_off)
        glob_en_q <= 1'b0; // R11
      if (wr_ok) begin
        case (mmr_idx)
          `TSEC_IDX_MASK:     mask_q <= mmr_wdata[15:0] | `TSEC_MASK_FIXED; // R11
          `TSEC_IDX_PMASK_LO: pmask_q[31:0] <= mmr_wdata; // R6
          `TSEC_IDX_PMASK_HI: pmask_q[NSRC-1:32] <= mmr_wdata[NSRC-33:0]; // R6
          `TSEC_IDX_PWAKE_LO: pwake_q[31:0] <= mmr_wdata; // R6
          `TSEC_IDX_PWAKE_HI: pwake_q[NSRC-1:32] <= mmr_wdata[NSRC-33:0]; // R6
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always @(posedge clk) begin
    if (!resetn) begin
      rdata_q    <= 32'h00000000;
      map_sel_q  <= 1'b0;
      mmr_rvalid <= 1'b0;
      mmr_err    <= 1'b0;
    end else begin
      mmr_rvalid <= mmr_rd;
      mmr_err    <= (mmr_rd | mmr_wr) & ~acc_ok;
      map_sel_q  <= rd_ok & is_map;
      if (mmr_rd) begin
        if (!acc_ok)
          rdata_q <= 32'h00000000;
        else begin
          case (mmr_idx)
            `TSEC_IDX_LATCH:    rdata_q <= {16'h0000, latch_q};
            `TSEC_IDX_MASK:     rdata_q <= {16'h0000, mask_q};
            `TSEC_IDX_PENDING:  rdata_q <= {16'h0000, pend_q}; // R12
            `TSEC_IDX_PMASK_LO: rdata_q <= pmask_w[31:0];
            `TSEC_IDX_PMASK_HI: rdata_q <= pmask_w[63:32];
            `TSEC_IDX_PSTAT_LO: rdata_q <= pstat_w[31:0]; // R14
            `TSEC_IDX_PSTAT_HI: rdata_q <= pstat_w[63:32]; // R14
            `TSEC_IDX_PWAKE_LO: rdata_q <= pwake_w[31:0];
            `TSEC_IDX_PWAKE_HI: rdata_q <= pwake_w[63:32];
            default:            rdata_q <= 32'h00000000;
          endcase
        end
      end
    end
  end

  assign mmr_rdata = map_sel_q ? map_rdata : rdata_q;

  // ****************************************************************
  // Wakeup
  // ****************************************************************
  always @(posedge clk) begin
    if (!resetn)
      wake_core <= 1'b0;
    else
      wake_core <= core_idle & (|(periph_req & pwake_q)); // R15
  end

endmodule // tsec_event_ctrl

// ---- sim/tsec_event_checker.sv ----
// Purpose: Port assertions for the event controller
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module tsec_event_checker #(
  parameter NSRC = 56
) (
  input logic            clk,
  input logic            resetn,
  input logic [NSRC-1:0] periph_req,
  input logic [6:0]      core_evt,
  input logic            core_idle,
  input logic            svc_take,
  input logic            mmr_sup,
  input logic            mmr_wr,
  input logic            mmr_rd,
  input logic            mmr_rvalid,
  input logic            mmr_err,
  input logic            svc_req,
  input logic [3:0]      svc_class,
  input logic            wake_core,
  input logic [NSRC-1:0] periph_ack
);
  // ********
  // Assertions
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (mmr_rd |=> mmr_rvalid) else $error("read not answered");
  a_stray_valid: assert property (!mmr_rd |=> !mmr_rvalid) else $error("stray read valid");
  a_user_refused: assert property ((mmr_rd || mmr_wr) |=> mmr_err == !$past(mmr_sup)) else $error("bad err");
  a_err_quiet: assert property (!(mmr_rd || mmr_wr) |=> !mmr_err) else $error("stray err");
  a_ack_cause: assert property ((periph_ack & ~periph_req) == '0) else $error("ack without request");
  a_take_clears: assert property (svc_take && svc_req |=> !svc_req || svc_class != $past(svc_class))
    else $error("offer kept after take");
  a_wake_cause: assert property (wake_core |-> $past(core_idle) && $past(|periph_req)) else $error("bad wake");
  a_edge_latency: assert property ($rose(core_evt[2]) && !svc_req |-> (!svc_req)[*2] ##[1:4] svc_req)
    else $error("edge latency");
  a_class_valid: assert property (svc_req |-> svc_class != 4'h4) else $error("reserved class offered");
endmodule // tsec_event_checker

bind tsec_event_ctrl tsec_event_checker #(.NSRC(NSRC)) u_tsec_event_checker (
  .clk        (clk),
  .resetn     (resetn),
  .periph_req (periph_req),
  .core_evt   (core_evt),
  .core_idle  (core_idle),
  .svc_take   (svc_take),
  .mmr_sup    (mmr_sup),
  .mmr_wr     (mmr_wr),
  .mmr_rd     (mmr_rd),
  .mmr_rvalid (mmr_rvalid),
  .mmr_err    (mmr_err),
  .svc_req    (svc_req),
  .svc_class  (svc_class),
  .wake_core  (wake_core),
  .periph_ack (periph_ack)
);

// ---- sim/tsec_core_model.sv ----
// Purpose: Core pipeline that takes offered events
// Assumes: Offer is a level, take is a pulse
// Notes:   Slow mode waits three cycles before taking
`timescale 1ns/1ps
module tsec_core_model (
  input  logic       clk,
  input  logic       resetn,
  input  logic       svc_req,
  input  logic [3:0] svc_class,
  input  logic       slow,
  output logic       svc_take,
  output logic [3:0] taken_class
);
  logic [1:0] wait_q;
  initial svc_take = 1'b0;
  // ********
  // Take logic
  // ********
  always @(posedge clk) begin
    if (!resetn) begin
      svc_take <= #10 1'b0;
      wait_q <= 2'h0;
      taken_class <= 4'hF;
    end else if (svc_take) begin
      svc_take <= #10 1'b0;
      wait_q <= 2'h0;
      if (svc_req) taken_class <= svc_class;
    end else if (svc_req && (!slow || wait_q == 2'h3)) begin
      svc_take <= #10 1'b1;
    end else begin
      wait_q <= svc_req ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule // tsec_core_model

// ---- sim/tsec_event_ctrl_test.sv ----
// Purpose: Self-checking bench for the event controller
// Assumes: Inputs change 10 ns after the rising edge
// Notes:   Register port driven by acc, core by model
`timescale 1ns/1ps
`include "tsec_regs.vh"
module tsec_event_ctrl_test;
  localparam DLY = 10;
  logic        clk, resetn, core_idle, mmr_sup, mmr_wr, mmr_rd, slow, er_q;
  logic [55:0] req;
  logic [6:0]  evt;
  logic [2:0]  ctl;
  logic [3:0]  idx;
  logic [31:0] wd, rd_q;
  logic [223:0] amap;
  wire  [31:0] rdata;
  wire         rvalid, err, sreq, take, wake;
  wire  [3:0]  scls, tcls;
  wire  [55:0] ack;
  int          bad_count, comparisons;
  tsec_event_ctrl #(.NSRC(56)) u_tsec_event_ctrl (.clk(clk), .resetn(resetn), .periph_req(req),
    .core_evt(evt), .core_idle(core_idle), .global_irq_on(ctl[1]), .global_irq_off(ctl[0]),
    .svc_take(take), .svc_ret(ctl[2]), .mmr_sup(mmr_sup), .mmr_wr(mmr_wr), .mmr_rd(mmr_rd),
    .mmr_idx(idx), .mmr_wdata(wd), .mmr_rdata(rdata), .mmr_rvalid(rvalid), .mmr_err(err),
    .svc_req(sreq), .svc_class(scls), .wake_core(wake), .periph_ack(ack));
  tsec_core_model u_tsec_core_model (.clk(clk), .resetn(resetn), .svc_req(sreq), .svc_class(scls),
    .slow(slow), .svc_take(take), .taken_class(tcls));
  // ********
  // Tasks
  // ********
  task give_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task acc(input logic w, input logic [3:0] i, input logic [31:0] d);
    @(posedge clk);
    #DLY;
    mmr_wr = w;
    mmr_rd = !w;
    idx = i;
    wd = d;
    @(posedge clk);
    #DLY;
    mmr_wr = 0;
    mmr_rd = 0;
    rd_q = rdata;
    er_q = err;
    if (!w) check("rvalid", 32'h1, {31'h0, rvalid});
  endtask
  task rchk(input logic [3:0] i, input logic [31:0] exp);
    acc(0, i, 32'h0);
    check("register", exp, rd_q);
  endtask
  task wait_pend(input logic [31:0] exp);
    int n;
    n = 0;
    acc(0, `TSEC_IDX_PENDING, 32'h0);
    while (rd_q !== exp && n < 30) begin
      acc(0, `TSEC_IDX_PENDING, 32'h0);
      n++;
    end
    check("pending", exp, rd_q);
    if (rd_q !== exp) give_verdict;
  endtask
  task pulse(input logic [2:0] v);
    @(posedge clk);
    #DLY ctl = v;
    @(posedge clk);
    #DLY ctl = 3'h0;
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #DLY;
  endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
  // ********
  // Main sequence
  // ********
  initial begin
    resetn = 0; core_idle = 0; mmr_sup = 1; mmr_wr = 0; mmr_rd = 0; slow = 0;
    req = '0; evt = '0; ctl = '0; idx = '0; wd = '0; amap = `TSEC_ASSIGN_RESET;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    #DLY resetn = 1;
    for (int k = 0; k < 16; k++) rchk(4'(k), k == 1 ? 32'h1F : (k > 8 ? amap[32*(k-9) +: 32] : 32'h0));
    mmr_sup = 0;
    acc(1, `TSEC_IDX_MASK, 32'hFFFF);
    acc(0, `TSEC_IDX_MASK, 32'h0);
    check("refused", 32'h0, rd_q);
    check("err", 32'h1, {31'h0, er_q});
    mmr_sup = 1;
    rchk(`TSEC_IDX_MASK, 32'h1F);
    req[3] = 1;
    req[40] = 1;
    settle(2);
    rchk(`TSEC_IDX_PSTAT_LO, 32'h8);
    rchk(`TSEC_IDX_PSTAT_HI, 32'h100);
    acc(1, `TSEC_IDX_MASK, 32'h109F);
    settle(6);
    check("offer", 32'h0, {31'h0, sreq});
    acc(1, `TSEC_IDX_PMASK_HI, 32'h100);
    wait_pend(32'h1000);
    check("class", 32'hC, {28'h0, tcls});
    check("ack", 32'h1, {31'h0, ack[40]});
    rchk(`TSEC_IDX_LATCH, 32'h0);
    acc(1, 4'hE, 32'h06666650);
    wait_pend(32'h1080);
    check("class", 32'h7, {28'h0, tcls});
    pulse(3'h4);
    wait_pend(32'h1000);
    pulse(3'h4);
    wait_pend(32'h0);
    slow = 1;
    pulse(3'h1);
    acc(1, `TSEC_IDX_LATCH, 32'h4080);
    rchk(`TSEC_IDX_LATCH, 32'h4000);
    acc(1, `TSEC_IDX_MASK, 32'h509F);
    settle(6);
    rchk(`TSEC_IDX_PENDING, 32'h0);
    rchk(`TSEC_IDX_LATCH, 32'h4000);
    pulse(3'h2);
    wait_pend(32'h4000);
    check("class", 32'hE, {28'h0, tcls});
    pulse(3'h4);
    wait_pend(32'h0);
    evt = 7'h04;
    wait_pend(32'h4);
    check("class", 32'h2, {28'h0, tcls});
    evt = 7'h0C;
    settle(4);
    rchk(`TSEC_IDX_LATCH, 32'h8);
    pulse(3'h4);
    wait_pend(32'h8);
    rchk(`TSEC_IDX_LATCH, 32'h0);
    evt = 7'h00;
    pulse(3'h4);
    core_idle = 1;
    settle(2);
    check("wake", 32'h0, {31'h0, wake});
    acc(1, `TSEC_IDX_PWAKE_HI, 32'h100);
    settle(2);
    check("wake", 32'h1, {31'h0, wake});
    rchk(`TSEC_IDX_PWAKE_HI, 32'h100);
    acc(1, `TSEC_IDX_PMASK_HI, 32'h301);
    req[32] = 1;
    req[41] = 1;
    wait_pend(32'h1000);
    check("ack", 32'h3, {30'h0, ack[41], ack[32]});
    rchk(`TSEC_IDX_PSTAT_HI, 32'h301);
    give_verdict;
  end
endmodule // tsec_event_ctrl_test
